// >>> bench/pwr_hs_sva.sv
// checker for the wake and clock-request lines between the two ends
`timescale 1ns/1ns
`default_nettype none
module pwr_hs_sva (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic dev_wake,
   input wire logic host_wake,
   input wire logic clk_req,
   input wire logic clk_on
);
   // ****************************************************
   // clock request answered by the host end
   // ****************************************************
   // polarity settles over the first edges after reset, so wait three
   logic [1:0] up_q;
   logic [1:0] up_d;
   always_comb begin
      up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         up_q <= 2'h0;
      end else begin
         up_q <= up_d;
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_req_moved;
      clk_req != $past(clk_req);
   endsequence
   sequence s_on_moved;
      clk_on != $past(clk_on);
   endsequence
   a_reset_idle: assert property (disable iff (i_rst_n)
      1'h1 |-> !clk_req && !host_wake) else $error("wake lines active in reset");
   a_req_answer: assert property ((up_q == 2'h3) ##0 s_req_moved |=> s_on_moved)
      else $error("clock answer missed request change");
   a_on_cause: assert property ((up_q == 2'h3) ##0 s_on_moved
      |-> $past(clk_req) != $past(clk_req, 2)) else $error("clock moved without request");
   a_on_pair: assert property ((up_q == 2'h3)
      |-> (clk_on ^ $past(clk_req)) == ($past(clk_on) ^ $past(clk_req, 2)))
      else $error("clock answer lost its pairing");
   a_req_hold: assert property ((up_q == 2'h3) ##0 !s_req_moved |=> !s_on_moved)
      else $error("clock answer moved on a steady request");
   a_req_settle: assert property ((up_q == 2'h3) ##0 s_req_moved ##1 s_on_moved
      |=> (clk_on ^ $past(clk_req)) == ($past(clk_on) ^ $past(clk_req, 2)))
      else $error("clock answer unsettled after request change");
   c_wake: cover property (s_req_moved ##1 s_on_moved);
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// top bench joining device end and host end of the wake handshake
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import pwr_hs_pkg::*;
   // ****************************************************
   // stimulus and checks
   // ****************************************************
   logic clk = 1'h0;
   logic rst_n, sel, en, wr, rdy, err, e, tx, rx, act, uart, strap, need, wpol, hpol, cpol;
   logic tx_pd, rx_pd, syn_pd, pa_pd, fm, osc, asleep, stay, con;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, r;
   int n_fail, checked, cyc, n;
   pwr_hs_if hs();
   bt_power_handshake i_bt_power_handshake(.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(sel),
      .i_penable(en), .i_pwrite(wr), .i_paddr(addr), .i_pwdata(wdata), .o_pready(rdy),
      .o_prdata(rdata), .o_pslverr(err), .i_pkt_tx(tx), .i_pkt_rx(rx), .i_pkt_active(act),
      .i_uart_mode(uart), .i_refclk_req_polarity_strap(strap), .o_tx_pd(tx_pd),
      .o_rx_pd(rx_pd), .o_synth_pd(syn_pd), .o_pa_pd(pa_pd), .o_fm_on(fm),
      .o_low_power_osc_sel(osc), .o_asleep(asleep), .hs(hs));
   bt_host_wake_end i_bt_host_wake_end(.i_core_clk(clk), .i_rst_n(rst_n), .i_need_dev(need),
      .i_wake_pol(wpol), .i_hwake_pol(hpol), .i_creq_pol(cpol), .o_must_stay_awake(stay),
      .o_clk_on(con), .hs(hs));
   pwr_hs_sva i_pwr_hs_sva(.i_core_clk(clk), .i_rst_n(rst_n), .dev_wake(hs.dev_wake),
      .host_wake(hs.host_wake), .clk_req(hs.clk_req), .clk_on(hs.clk_on));
   always #25 clk = ~clk;
   task automatic final_report();
      if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   // leading edge keeps two transfers from touching psel in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      sel <= 1'h1;
      wr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      en <= 1'h1;
      do @(posedge clk); while (rdy !== 1'h1);
      r = rdata;
      e = err;
      sel <= 1'h0;
      en <= 1'h0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk(r, x);
   endtask
   task automatic rst_seq(input logic s);
      rst_n <= 1'h0;
      strap <= s;
      cpol <= s;
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
   endtask
   initial begin
      {sel, en, wr, addr, wdata, tx, rx, act, uart, need, wpol, hpol, strap, cpol} = '0;
      rst_n = 1'h0;
      rst_seq(1'h0);
      rdc(CTRL_OFF, 32'(CTRL_RST));
      rdc(RF_OFF, 32'(RF_RST));
      rdc(SLEEP_OFF, 32'(SLEEP_RST));
      rdc(STATUS_OFF, 32'hf8);
      rdc(8'h10, 32'h0);
      chk(e, 1'h1);
      tx <= 1'h1;
      repeat (2) @(posedge clk);
      chk({pa_pd, syn_pd, rx_pd, tx_pd}, 4'h2);
      tx <= 1'h0;
      rx <= 1'h1;
      repeat (2) @(posedge clk);
      chk({pa_pd, syn_pd, rx_pd, tx_pd}, 4'h9);
      rx <= 1'h0;
      apb(1'h1, RF_OFF, 32'h5);
      apb(1'h1, CTRL_OFF, 32'h18);
      apb(1'h1, 8'h10, 32'hff);
      chk({fm, pa_pd, syn_pd, rx_pd, tx_pd}, 5'h15);
      rdc(CTRL_OFF, 32'h18);
      apb(1'h1, CTRL_OFF, 32'h0c);
      repeat (2) @(posedge clk);
      chk({fm, pa_pd, syn_pd, rx_pd, tx_pd, hs.host_wake}, 6'h0b);
      act <= 1'h1;
      uart <= 1'h1;
      apb(1'h1, SLEEP_OFF, 32'h1);
      apb(1'h1, CTRL_OFF, 32'ha1);
      repeat (10) @(posedge clk);
      chk(asleep, 1'h0);
      act <= 1'h0;
      while (asleep !== 1'h1) @(posedge clk);
      chk({osc, hs.clk_req}, 2'h2);
      n = 0;
      while (asleep !== 1'h0) begin
         @(posedge clk);
         n++;
      end
      chk(n > 600, 1'h1);
      need <= 1'h1;
      repeat (12) @(posedge clk);
      chk({asleep, con}, 2'h1);
      apb(1'h1, CTRL_OFF, 32'he1);
      repeat (3) @(posedge clk);
      chk(stay, 1'h1);
      uart <= 1'h0;
      repeat (3) @(posedge clk);
      chk(hs.host_wake, 1'h0);
      rst_seq(1'h1);
      rdc(STATUS_OFF, 32'hf0);
      chk(con, 1'h1);
      final_report();
   end
endmodule
`default_nettype wire

// >>> core/bt_host_wake_end.sv
// host end: drives device wake, answers clock request, reports host wake
`timescale 1ns/1ns
`default_nettype none
module bt_host_wake_end (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_need_dev,
   input wire logic i_wake_pol,
   input wire logic i_hwake_pol,
   input wire logic i_creq_pol,
   output logic o_must_stay_awake,
   output logic o_clk_on,
   pwr_hs_if.host hs
);
   import pwr_hs_pkg::*;
   logic wake_q, wake_d, clk_q, clk_d, stay_q, stay_d;
   always_comb begin
      wake_d = i_need_dev ^ i_wake_pol;
      clk_d = hs.clk_req ^ i_creq_pol;
      stay_d = hs.host_wake ^ i_hwake_pol;
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wake_q <= 1'b0;
         clk_q <= 1'b0;
         stay_q <= 1'b0;
      end else begin
         wake_q <= wake_d;
         clk_q <= clk_d;
         stay_q <= stay_d;
      end
   end
   assign hs.dev_wake = wake_q;
   assign hs.clk_on = clk_q;
   assign o_clk_on = clk_q;
   assign o_must_stay_awake = stay_q;
endmodule
`default_nettype wire

// >>> core/bt_power_handshake.sv
// device end: power management unit with apb registers and wake handshake
`timescale 1ns/1ns
`default_nettype none
module bt_power_handshake (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   input wire logic i_pkt_tx,
   input wire logic i_pkt_rx,
   input wire logic i_pkt_active,
   input wire logic i_uart_mode,
   input wire logic i_refclk_req_polarity_strap,
   output logic o_tx_pd,
   output logic o_rx_pd,
   output logic o_synth_pd,
   output logic o_pa_pd,
   output logic o_fm_on,
   output logic o_low_power_osc_sel,
   output logic o_asleep,
   pwr_hs_if.dev hs
);
   import pwr_hs_pkg::*;
   // ****************************************************
   // registers
   // ****************************************************
   logic [7:0] ctrl_q, ctrl_d;
   logic [3:0] rf_q, rf_d;
   logic [15:0] sleep_q, sleep_d;
   logic strap_q, strap_d, strap_done_q, strap_done_d;
   logic wake_s1_q, wake_s2_q;
   logic lpo_s1_q, lpo_s2_q;
   logic [LPO_DIV_W-1:0] div_q, div_d;
   logic [15:0] tmr_q, tmr_d;
   pwr_state_t st_q, st_d;
   logic [3:0] pd_q, pd_d;
   logic hwake_q, hwake_d, creq_q, creq_d;
   logic wr, lpo_tick, wake_act, hs_en, clk_need;
   assign wr = i_psel && i_penable && i_pwrite;
   assign o_pready = 1'b1;
   assign hs_en = ctrl_q[CTRL_UART_HS] && i_uart_mode;
   // two flops; the second also feeds the lpo-rate sampler
   assign wake_act = hs_en && (wake_s2_q ^ ctrl_q[CTRL_WAKE_POL]);
   assign lpo_tick = (div_q == LPO_DIV_W'(LPO_DIV - 1));
   always_comb begin
      ctrl_d = ctrl_q;
      rf_d = rf_q;
      sleep_d = sleep_q;
      if (wr && i_paddr == CTRL_OFF) begin
         ctrl_d = i_pwdata[7:0];
      end
      if (wr && i_paddr == RF_OFF) begin
         rf_d = i_pwdata[3:0];
      end
      if (wr && i_paddr == SLEEP_OFF) begin
         sleep_d = i_pwdata[15:0];
      end
      strap_d = strap_q;
      strap_done_d = 1'b1;
      if (!strap_done_q) begin
         strap_d = i_refclk_req_polarity_strap; // caught once after reset release
      end
      div_d = lpo_tick ? '0 : div_q + 1'b1;
   end
   always_comb begin
      o_prdata = 32'h0;
      o_pslverr = 1'b0;
      case (i_paddr)
         CTRL_OFF: o_prdata = {24'h0, ctrl_q};
         RF_OFF: o_prdata = {28'h0, rf_q};
         SLEEP_OFF: o_prdata = {16'h0, sleep_q};
         STATUS_OFF: o_prdata = {24'h0, pd_q, creq_q, hwake_q, st_q};
         default: o_pslverr = i_psel && i_penable;
      endcase
   end
   // ****************************************************
   // sleep state machine
   // ****************************************************
   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      case (st_q)
         PS_AWAKE: begin
            // sleep only with idle link and software permission
            if (ctrl_q[CTRL_LP_MODE] && ctrl_q[CTRL_ALLOW_SLEEP] && !wake_act && !i_pkt_active) begin
               st_d = PS_LP_SLEEP;
               tmr_d = sleep_q;
            end
         end
         PS_LP_SLEEP: begin
            if (wake_act) begin
               st_d = PS_WAKING;
            end else if (lpo_tick) begin
               if (tmr_q == 16'h0) begin
                  st_d = PS_WAKING;
               end else begin
                  tmr_d = tmr_q - 1'b1;
               end
            end
         end
         PS_WAKING: begin
            // waits for reference clock before core resumes
            if (hs.clk_on) begin
               st_d = PS_AWAKE;
            end
         end
         default: st_d = PS_AWAKE;
      endcase
      clk_need = (st_d != PS_LP_SLEEP);
      creq_d = strap_q ? !clk_need : clk_need;
      hwake_d = (hs_en && ctrl_q[CTRL_HOST_REQ]) ^ ctrl_q[CTRL_HWAKE_POL];
      // packet handling overrides only when CTRL_SW_RF is clear
      pd_d = 4'hf;
      if (st_d == PS_AWAKE) begin
         if (ctrl_q[CTRL_SW_RF]) begin
            pd_d = rf_q;
         end else begin
            pd_d[0] = !i_pkt_tx;
            pd_d[1] = !i_pkt_rx;
            pd_d[2] = !(i_pkt_tx || i_pkt_rx);
            pd_d[3] = !i_pkt_tx;
         end
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q <= CTRL_RST;
         rf_q <= RF_RST;
         sleep_q <= SLEEP_RST;
         strap_q <= 1'b0;
         strap_done_q <= 1'b0;
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
         lpo_s1_q <= 1'b0;
         lpo_s2_q <= 1'b0;
         div_q <= '0;
         tmr_q <= '0;
         st_q <= PS_AWAKE;
         pd_q <= 4'hf;
         hwake_q <= 1'b0;
         creq_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         rf_q <= rf_d;
         sleep_q <= sleep_d;
         strap_q <= strap_d;
         strap_done_q <= strap_done_d;
         wake_s1_q <= hs.dev_wake;
         wake_s2_q <= wake_s1_q;
         if (lpo_tick) begin
            lpo_s1_q <= wake_s2_q; // copy at oscillator rate
         end
         lpo_s2_q <= lpo_s1_q;
         div_q <= div_d;
         tmr_q <= tmr_d;
         st_q <= st_d;
         pd_q <= pd_d;
         hwake_q <= hwake_d;
         creq_q <= creq_d;
      end
   end
   assign {o_pa_pd, o_synth_pd, o_rx_pd, o_tx_pd} = pd_q;
   assign o_fm_on = ctrl_q[CTRL_FM_ON];
   assign o_low_power_osc_sel = (st_q == PS_LP_SLEEP);
   assign o_asleep = (st_q == PS_LP_SLEEP);
   assign hs.host_wake = hwake_q;
   assign hs.clk_req = creq_q;
endmodule
`default_nettype wire

// >>> core/pwr_hs_if.sv
// sideband wake lines between the radio device and its host
`timescale 1ns/1ns
`default_nettype none
interface pwr_hs_if;
   logic dev_wake;
   logic host_wake;
   logic clk_req;
   logic clk_on;
   modport dev (input dev_wake, input clk_on, output host_wake, output clk_req);
   modport host (output dev_wake, output clk_on, input host_wake, input clk_req);
endinterface
`default_nettype wire

// >>> core/pwr_hs_pkg.sv
// package of constants and types for the radio power handshake
package pwr_hs_pkg;
   // ****************************************************
   // register map (apb, one aligned word each)
   // ****************************************************
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] RF_OFF = 8'h04;
   localparam logic [7:0] SLEEP_OFF = 8'h08;
   localparam logic [7:0] STATUS_OFF = 8'h0c;
   // ctrl bits
   localparam int CTRL_UART_HS = 0;
   localparam int CTRL_WAKE_POL = 1;
   localparam int CTRL_HWAKE_POL = 2;
   localparam int CTRL_SW_RF = 3;
   localparam int CTRL_FM_ON = 4;
   localparam int CTRL_LP_MODE = 5;
   localparam int CTRL_HOST_REQ = 6;
   localparam int CTRL_ALLOW_SLEEP = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // rf power-down field bits: tx, rx, synth, pa
   localparam logic [3:0] RF_RST = 4'hf;
   localparam logic [15:0] SLEEP_RST = 16'h0100;
   // ****************************************************
   // timing
   // ****************************************************
   localparam int LPO_DIV = 610;
   localparam int LPO_DIV_W = 10;
   typedef enum logic [1:0] {
      PS_AWAKE,
      PS_LP_SLEEP,
      PS_WAKING
   } pwr_state_t;
endpackage
